// *** verilog/lfm_fault_manager.sv ***
// LED backlight driver fault manager: boost gating and string fault marks
// What this block does
// - Stop boost switching at output over-voltage
// - Restart switching below the recovery threshold
// - Switch only while output sense above floor
// - On over-voltage, mark low-sink strings open
// - Exclude marked strings; lowest active sink regulates
// - Open-marked string recovers when reconnected
// - All strings open latches regulator off
// - Detect short when sink exceeds short level
// - Persistent short disables string after fault time
// - Shorted string recovers once short clears
// - Over-temperature shutdown with hysteretic resume
// - Check sense, supply, temperature before soft start
`timescale 1ns/100ps
`include "lfm_defines.svh"

module lfm_fault_manager
  import lfm_pkg::*;
#(
  parameter int NS = `LFM_NUM_STRINGS,
  parameter int SHORT_CYC = `LFM_SHORT_FAULT_CYC,
  parameter int SOFT_CYC = `LFM_SOFT_START_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic supplyOk,
  input wire logic senseHigh,
  input wire logic senseRecovered,
  input wire logic senseAboveFloor,
  input wire logic [NS-1:0] sinkLow,
  input wire logic [NS-1:0] sinkHigh,
  input wire logic tempHigh,
  input wire logic tempLow,
  input wire logic [NS-1:0] sinkLowest,
  output logic boostEnable,
  output logic softStart,
  output logic regulatorOn,
  output logic [NS-1:0] stringActive,
  output logic [NS-1:0] stringOpen,
  output logic [NS-1:0] stringShort,
  output logic [NS-1:0] loopSelect,
  output logic ovpStop,
  output logic thermalStop,
  output logic allOpenLatched
);

  localparam int SW = $clog2(SOFT_CYC + 1);

  typedef struct packed {
    lfm_state_e state;
    logic [SW-1:0] softCnt;
    logic output_sense_input;
    logic hot;
    logic [NS-1:0] open;
    logic [NS-1:0] sel;
    logic boost;
  } lfm_state_s;

  lfm_state_s st_q, st_d;
  logic [NS-1:0] shortOff;
  logic runOk;

  ////////////////////////////////////////////////////////////////////////
  // Short qualification, one timer per string

  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_short
      lfm_short_timer #(
        .FAULT_CYC(SHORT_CYC)
      ) u_tmr (
        .clk(clk),
        .rst_n(rst_n),
        .enable(regulatorOn),
        .shortHigh(sinkHigh[gi]),
        .shortOff(shortOff[gi])
      );
    end
  endgenerate

  // Picks lowest-voltage active string; where several sinkLowest bits are set, the lowest-numbered active string wins
  function automatic logic [NS-1:0] pickLoop(
    input logic [NS-1:0] lowest,
    input logic [NS-1:0] active
  );
    logic [NS-1:0] m;
    m = lowest & active;
    pickLoop = '0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (m[i]) begin
        pickLoop = '0;
        pickLoop[i] = 1'b1;
      end
    end
  endfunction : pickLoop

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    st_d = st_q;
    if (tempHigh) begin
      st_d.hot = 1'b1;
    end else if (tempLow) begin
      st_d.hot = 1'b0;
    end
    if (senseHigh) begin
      st_d.output_sense_input = 1'b1;
    end else if (senseRecovered) begin
      st_d.output_sense_input = 1'b0;
    end
    st_d.open = st_q.open & sinkLow;
    if (senseHigh) begin
      st_d.open = st_q.open | sinkLow;
    end
    st_d.sel = pickLoop(sinkLowest, ~st_d.open & ~shortOff);
    runOk = senseAboveFloor && !st_d.output_sense_input && !st_d.hot;
    st_d.boost = 1'b0;
    case (st_q.state)
      LFM_OFF: begin
        st_d.softCnt = '0;
        st_d.open = '0;
        // Supply must be up as well as enable
        if (enable && supplyOk) begin
          st_d.state = LFM_CHECK;
        end
      end
      LFM_CHECK: begin
        if (senseAboveFloor && supplyOk && !st_q.hot) begin
          st_d.state = LFM_SOFT;
        end
      end
      LFM_SOFT, LFM_RUN: begin
        st_d.boost = runOk;
        if (st_q.state == LFM_SOFT) begin
          if (st_q.softCnt == SW'(SOFT_CYC)) begin
            st_d.state = LFM_RUN;
          end else begin
            st_d.softCnt = st_q.softCnt + SW'(1);
          end
        end
        if (senseHigh && (&sinkLow)) begin
          st_d.state = LFM_LATCHED;
          st_d.boost = 1'b0;
        end
      end
      LFM_LATCHED: begin
        st_d.boost = 1'b0;
      end
      default: begin
        st_d.state = LFM_OFF;
      end
    endcase
    if (st_d.hot && st_q.state != LFM_LATCHED) begin
      st_d.boost = 1'b0;
    end
    // Leaving enable or supply clears the latch
    if (!enable || !supplyOk) begin
      st_d.state = LFM_OFF;
      st_d.boost = 1'b0;
      st_d.open = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '{state: LFM_OFF, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign boostEnable = st_q.boost;
  assign softStart = (st_q.state == LFM_SOFT);
  assign regulatorOn = (st_q.state == LFM_SOFT) ||
                       (st_q.state == LFM_RUN);
  assign stringOpen = st_q.open;
  assign stringShort = shortOff;
  assign stringActive = regulatorOn ? (~st_q.open & ~shortOff) : '0;
  assign loopSelect = regulatorOn ? st_q.sel : '0;
  assign ovpStop = st_q.output_sense_input;
  assign thermalStop = st_q.hot;
  assign allOpenLatched = (st_q.state == LFM_LATCHED);

endmodule : lfm_fault_manager

// *** verilog/lfm_defines.svh ***
// Constants of the LED fault manager: timing figures and derived counts
`ifndef LFM_DEFINES_SVH
`define LFM_DEFINES_SVH

`define LFM_CLK_MHZ 100
`define LFM_SHORT_FAULT_US 3200
`define LFM_SHORT_FAULT_CYC (`LFM_SHORT_FAULT_US * `LFM_CLK_MHZ)
`define LFM_SOFT_START_US 1000
`define LFM_SOFT_START_CYC (`LFM_SOFT_START_US * `LFM_CLK_MHZ)
`define LFM_NUM_STRINGS 6

`endif

// *** verilog/lfm_pkg.sv ***
// Types of the LED fault manager
package lfm_pkg;

  typedef enum logic [4:0] {
    LFM_OFF     = 5'h01,
    LFM_CHECK   = 5'h02,
    LFM_SOFT    = 5'h04,
    LFM_RUN     = 5'h08,
    LFM_LATCHED = 5'h10
  } lfm_state_e;

endpackage : lfm_pkg

// *** verilog/lfm_short_timer.sv ***
// Per-string short-fault qualification timer
`timescale 1ns/100ps
`include "lfm_defines.svh"

module lfm_short_timer
  import lfm_pkg::*;
#(
  parameter int FAULT_CYC = `LFM_SHORT_FAULT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic shortHigh,
  output logic shortOff
);

  localparam int CW = $clog2(FAULT_CYC + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic off;
  } lfm_tmr_s;

  lfm_tmr_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (!enable || !shortHigh) begin
      st_d.cnt = '0;
      st_d.off = 1'b0;
    end else if (st_q.cnt == CW'(FAULT_CYC)) begin
      st_d.off = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign shortOff = st_q.off;

endmodule : lfm_short_timer

// *** sim/lfm_fault_props.sv ***
// Port assertions of the fault manager
`timescale 1ns/100ps
module lfm_fault_props
  import lfm_pkg::*;
#(parameter int NS = 6) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic supplyOk,
  input wire logic senseHigh,
  input wire logic senseRecovered,
  input wire logic senseAboveFloor,
  input wire logic tempHigh,
  input wire logic [NS-1:0] sinkLow,
  input wire logic [NS-1:0] sinkHigh,
  input wire logic boostEnable,
  input wire logic regulatorOn,
  input wire logic ovpStop,
  input wire logic allOpenLatched,
  input wire logic [NS-1:0] stringOpen,
  input wire logic [NS-1:0] stringShort
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic on;
  assign on = regulatorOn & enable & supplyOk;
  sequence shortBegins;
    $rose(sinkHigh[0]) && on;
  endsequence
  chk_ovp_stop: assert property (senseHigh && on |=> !boostEnable)
    else $error("boost kept at overvoltage");
  chk_floor_gate: assert property (!senseAboveFloor |=> !boostEnable)
    else $error("boost below floor");
  chk_ovp_clear: assert property (ovpStop && senseRecovered && !senseHigh
    |=> !ovpStop) else $error("stop not cleared");
  chk_open_mark: assert property (senseHigh && on && sinkLow != '1
    |=> (stringOpen & $past(sinkLow)) == $past(sinkLow))
    else $error("open string not marked");
  chk_all_open: assert property (senseHigh && on && sinkLow == '1
    |=> allOpenLatched && !regulatorOn) else $error("all open not latched");
  chk_latch_hold: assert property (allOpenLatched && enable && supplyOk
    |=> allOpenLatched) else $error("latch lost");
  chk_hot_stop: assert property (tempHigh |=> !boostEnable)
    else $error("boost while hot");
  chk_short_wait: assert property (shortBegins |=> !stringShort[0] [*8])
    else $error("short disable too early");
  chk_short_clear: assert property ((stringShort & ~$past(sinkHigh)) == '0)
    else $error("short kept after clear");
endmodule : lfm_fault_props

bind lfm_fault_manager lfm_fault_props #(.NS(NS)) u_props (.*);

// *** sim/tb.sv ***
// Self-checking bench of the fault manager
`timescale 1ns/100ps
module tb;
  import lfm_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, enable = 1'b0, supplyOk = 1'b1;
  logic senseHigh = 1'b0, senseRecovered = 1'b1, senseAboveFloor = 1'b0;
  logic tempHigh = 1'b0, tempLow = 1'b1;
  logic [5:0] sinkLow = 6'h00, sinkHigh = 6'h00, sinkLowest = 6'h01;
  logic boostEnable, softStart, regulatorOn, ovpStop, thermalStop;
  logic allOpenLatched;
  logic [5:0] stringActive, stringOpen, stringShort, loopSelect;
  int n_mismatch = 0, checks_done = 0;
  always #5 clk = ~clk;
  // Short counts keep the run brief
  lfm_fault_manager #(.SHORT_CYC(8), .SOFT_CYC(4)) dut (.*);
  ////////////////////////////////////////
  task cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : cyc
  task chk(input string nm, input logic [5:0] e, input logic [5:0] g);
    checks_done++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task t_start;
    enable <= 1'b1;
    cyc(4);
    chk("boostNoFloor", 6'h00, boostEnable);
    @(posedge clk);
    senseAboveFloor <= 1'b1;
    for (int i = 0; i < 20 && (softStart || !regulatorOn); i++) cyc(0);
    chk("running", 6'h01, regulatorOn & ~softStart);
    if (n_mismatch > 0) report_and_stop;
    chk("boostRun", 6'h01, boostEnable);
    @(posedge clk);
    senseAboveFloor <= 1'b0;
    cyc(2);
    chk("boostFloor", 6'h00, boostEnable);
    @(posedge clk);
    senseAboveFloor <= 1'b1;
    cyc(2);
    chk("boostFloorBack", 6'h01, boostEnable);
  endtask : t_start
  task t_ovp;
    @(posedge clk);
    sinkLow <= 6'h05;
    senseHigh <= 1'b1;
    senseRecovered <= 1'b0;
    sinkLowest <= 6'h07;
    cyc(3);
    chk("open", 6'h05, stringOpen);
    chk("boostOvp", 6'h00, boostEnable);
    chk("loop", 6'h02, loopSelect);
    @(posedge clk);
    senseHigh <= 1'b0;
    cyc(2);
    chk("ovpHeld", 6'h01, ovpStop);
    @(posedge clk);
    senseRecovered <= 1'b1;
    cyc(2);
    chk("boostBack", 6'h01, boostEnable);
    @(posedge clk);
    sinkLow <= 6'h00;
    cyc(2);
    chk("reconnect", 6'h00, stringOpen);
  endtask : t_ovp
  task t_short;
    @(posedge clk);
    sinkHigh <= 6'h01;
    cyc(5);
    @(posedge clk);
    sinkHigh <= 6'h00;
    @(posedge clk);
    sinkHigh <= 6'h01;
    cyc(6);
    chk("shortEarly", 6'h00, stringShort);
    cyc(6);
    chk("short", 6'h01, stringShort);
    chk("active", 6'h3E, stringActive);
    chk("loopShort", 6'h02, loopSelect);
    @(posedge clk);
    sinkHigh <= 6'h00;
    cyc(2);
    chk("shortGone", 6'h00, stringShort);
  endtask : t_short
  task t_temp;
    @(posedge clk);
    tempHigh <= 1'b1;
    tempLow <= 1'b0;
    cyc(2);
    chk("hot", 6'h01, thermalStop & ~boostEnable);
    @(posedge clk);
    tempHigh <= 1'b0;
    cyc(2);
    chk("hotHyst", 6'h00, boostEnable);
    @(posedge clk);
    tempLow <= 1'b1;
    cyc(2);
    chk("cool", 6'h01, boostEnable);
  endtask : t_temp
  task t_all_open;
    @(posedge clk);
    sinkLow <= 6'h3F;
    senseHigh <= 1'b1;
    cyc(2);
    chk("latched", 6'h01, allOpenLatched & ~regulatorOn);
    @(posedge clk);
    sinkLow <= 6'h00;
    senseHigh <= 1'b0;
    cyc(3);
    chk("latchHeld", 6'h01, allOpenLatched);
    @(posedge clk);
    enable <= 1'b0;
    cyc(2);
    chk("latchFree", 6'h00, allOpenLatched);
  endtask : t_all_open
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_start();
    t_ovp();
    t_short();
    t_temp();
    t_all_open();
    report_and_stop();
  end
endmodule : tb
